// ---- src/pdl_indicator.sv ----
// indicator output: one source selector driving one registered led level
`timescale 1ns/1ps
`default_nettype none
module pdl_indicator
  import pdl_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // selection and status
  input wire logic [3:0] source_in,
  input wire pdl_phy_status_t status_in,
  // indicator
  output logic led_out
);

  typedef struct packed {
    logic led;
  } pdl_ind_state_t;

  pdl_ind_state_t state;
  pdl_ind_state_t next_state;

  // ----------------------------------------
  // source decode
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (source_in)
      PDL_SRC_LINK: begin
        next_state.led = status_in.link_good;
      end
      PDL_SRC_ACT: begin
        next_state.led = status_in.activity;
      end
      PDL_SRC_FAST: begin
        next_state.led = status_in.speed_100;
      end
      PDL_SRC_SLOW: begin
        next_state.led = ~status_in.speed_100;
      end
      PDL_SRC_FDX: begin
        next_state.led = status_in.full_duplex_result;
      end
      PDL_SRC_LINK_BLINK: begin
        next_state.led = status_in.link_good & ~(status_in.activity & status_in.blink);
      end
      default: begin
        next_state.led = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign led_out = state.led;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_ind_link;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (source_in == PDL_SRC_LINK) |=> (led_out == $past(status_in.link_good));
  endproperty
  a_ind_link: assert property (p_ind_link) else $error("led not following link");

  property p_ind_reserved;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (source_in inside {4'h2, 4'h3, 4'h4}) |=> !led_out;
  endproperty
  a_ind_reserved: assert property (p_ind_reserved) else $error("reserved source lit led");

endmodule
`default_nettype wire

// ---- src/pdl_pkg.sv ----
// package: register map, field layout and types of the diagnostic/led/crossover register bank
// Function
// - the negotiation-failed flag at bit 12 is set when negotiation ends without a shared technology, holds until the register is read, and the read clears it.
// - bit 11 reports the negotiated duplex, one for full and zero for half.
// - bit 10 reports the negotiated speed, one for 100 Mb/s and zero for 10 Mb/s.
// - bit 9 is set when a receive signal (100 Mb/s) or Manchester data (10 Mb/s) is detected.
// - bit 8 is set while the receive loop is locked at the selected speed.
// - the negotiation diagnostic register is at address 0x12, read-only except the clear-on-read flag, and resets to zero.
// - the two-bit amplitude field at bits 15:14 selects 0.0, 0.4, 0.8 or 1.2 dB compensation for codes 0 to 3.
// - the transceiver control register is at address 0x13, read/write, reset 0x4000.
// - bits 7:4 choose the second indicator source and default to activity, code 1.
// - bits 3:0 choose the first indicator source and default to link good, code 0.
// - source codes decode as 0 link, 1 activity, 5 fast, 6 slow, 7 full duplex, 8 link blinking on activity; 2 to 4 are reserved.
// - the indicator register is at address 0x17, read/write, reset 0x0010, upper byte reads zero.
// - the crossover register is at address 0x18, read/write, reset 0x00c0.
// - a crossover seed programmed as zero is replaced by a seed of 5.
// - the registers are reached over the management serial path by register address.
package pdl_pkg;

  // ----------------------------------------
  // register addresses
  // ----------------------------------------
  localparam logic [4:0] PDL_ADDR_DIAG = 5'h12;
  localparam logic [4:0] PDL_ADDR_GAIN = 5'h13;
  localparam logic [4:0] PDL_ADDR_IND = 5'h17;
  localparam logic [4:0] PDL_ADDR_XOVR = 5'h18;

  // ----------------------------------------
  // reset values and writable masks
  // ----------------------------------------
  localparam logic [15:0] PDL_RST_DIAG = 16'h0000;
  localparam logic [15:0] PDL_RST_GAIN = 16'h4000;
  localparam logic [15:0] PDL_RST_IND = 16'h0010;
  localparam logic [15:0] PDL_RST_XOVR = 16'h00c0;
  localparam logic [15:0] PDL_MASK_GAIN = 16'hc000;
  localparam logic [15:0] PDL_MASK_IND = 16'h00ff;
  localparam logic [15:0] PDL_MASK_XOVR = 16'hffff;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int PDL_BIT_FAIL = 12;
  localparam int PDL_BIT_FULL_DUPLEX_RESULT = 11;
  localparam int PDL_BIT_SPEED = 10;
  localparam int PDL_BIT_SIGDET = 9;
  localparam int PDL_BIT_LOCK = 8;
  localparam int PDL_AMP_LSB = 14;
  localparam int PDL_IND_B_LSB = 4;
  localparam int PDL_IND_A_LSB = 0;
  localparam int PDL_SEED_LSB = 0;
  localparam logic [3:0] PDL_SEED_DEFAULT = 4'h5;

  // ----------------------------------------
  // indicator source codes
  // ----------------------------------------
  typedef enum logic [3:0] {
    PDL_SRC_LINK = 4'h0,
    PDL_SRC_ACT = 4'h1,
    PDL_SRC_FAST = 4'h5,
    PDL_SRC_SLOW = 4'h6,
    PDL_SRC_FDX = 4'h7,
    PDL_SRC_LINK_BLINK = 4'h8
  } pdl_src_t;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic neg_done;
    logic neg_fail;
    logic full_duplex_result;
    logic speed_100;
    logic receive_signal_detected;
    logic rx_lock;
    logic link_good;
    logic activity;
    logic blink;
  } pdl_phy_status_t;

  typedef struct packed {
    logic req;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } pdl_mgmt_req_t;

  typedef struct packed {
    logic ack;
    logic hit;
    logic [15:0] rdata;
  } pdl_mgmt_rsp_t;

  typedef struct packed {
    logic [1:0] transmit_amplitude_code;
    logic indicator_a;
    logic indicator_b;
    logic [3:0] crossover_seed;
  } pdl_ctrl_t;

endpackage

// ---- src/pdl_regs.sv ----
// diagnostic, transceiver gain, indicator and crossover register bank
`timescale 1ns/1ps
`default_nettype none
module pdl_regs
  import pdl_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // management access
  input wire pdl_mgmt_req_t mgmt_req_in,
  output pdl_mgmt_rsp_t mgmt_rsp_out,
  // transceiver status
  input wire pdl_phy_status_t phy_status_in,
  // controls and indicators
  output pdl_ctrl_t ctrl_out
);

  typedef struct packed {
    logic neg_fail;
    logic full_duplex_result;
    logic speed_100;
    logic receive_signal_detected;
    logic rx_lock;
    logic [15:0] gain;
    logic [7:0] ind;
    logic [15:0] xovr;
    pdl_mgmt_rsp_t rsp;
    logic [1:0] amp;
    logic [3:0] seed;
  } pdl_reg_state_t;

  pdl_reg_state_t state;
  pdl_reg_state_t next_state;
  logic led_a;
  logic led_b;
  logic rd_diag;
  logic wr_hit;
  logic [15:0] diag_word;

  // ----------------------------------------
  // access decode
  // ----------------------------------------
  assign rd_diag = mgmt_req_in.req & ~mgmt_req_in.wr & (mgmt_req_in.addr == PDL_ADDR_DIAG);
  assign wr_hit = mgmt_req_in.req & mgmt_req_in.wr;

  always_comb begin
    diag_word = PDL_RST_DIAG;
    diag_word[PDL_BIT_FAIL] = state.neg_fail;
    diag_word[PDL_BIT_FULL_DUPLEX_RESULT] = state.full_duplex_result;
    diag_word[PDL_BIT_SPEED] = state.speed_100;
    diag_word[PDL_BIT_SIGDET] = state.receive_signal_detected;
    diag_word[PDL_BIT_LOCK] = state.rx_lock;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_state.full_duplex_result = phy_status_in.full_duplex_result;
    next_state.speed_100 = phy_status_in.speed_100;
    next_state.receive_signal_detected = phy_status_in.receive_signal_detected;
    next_state.rx_lock = phy_status_in.rx_lock;
    // read clears, a failure in the same cycle wins
    if (rd_diag) begin
      next_state.neg_fail = 1'b0;
    end
    if (phy_status_in.neg_done & phy_status_in.neg_fail) begin
      next_state.neg_fail = 1'b1;
    end
    // writes keep read-only and reserved bits
    if (wr_hit) begin
      case (mgmt_req_in.addr)
        PDL_ADDR_GAIN: begin
          next_state.gain = mgmt_req_in.wdata & PDL_MASK_GAIN;
        end
        PDL_ADDR_IND: begin
          next_state.ind = mgmt_req_in.wdata[7:0];
        end
        PDL_ADDR_XOVR: begin
          next_state.xovr = mgmt_req_in.wdata & PDL_MASK_XOVR;
        end
        default: begin
          next_state.gain = state.gain;
        end
      endcase
    end
    // response one cycle after the request
    next_state.rsp.ack = mgmt_req_in.req;
    next_state.rsp.hit = 1'b0;
    next_state.rsp.rdata = 16'h0000;
    if (mgmt_req_in.req) begin
      case (mgmt_req_in.addr)
        PDL_ADDR_DIAG: begin
          next_state.rsp.hit = 1'b1;
          next_state.rsp.rdata = mgmt_req_in.wr ? 16'h0000 : diag_word;
        end
        PDL_ADDR_GAIN: begin
          next_state.rsp.hit = 1'b1;
          next_state.rsp.rdata = mgmt_req_in.wr ? 16'h0000 : state.gain;
        end
        PDL_ADDR_IND: begin
          next_state.rsp.hit = 1'b1;
          next_state.rsp.rdata = mgmt_req_in.wr ? 16'h0000 : {8'h00, state.ind};
        end
        PDL_ADDR_XOVR: begin
          next_state.rsp.hit = 1'b1;
          next_state.rsp.rdata = mgmt_req_in.wr ? 16'h0000 : state.xovr;
        end
        default: begin
          next_state.rsp.hit = 1'b0;
        end
      endcase
    end
    next_state.amp = next_state.gain[PDL_AMP_LSB +: 2];
    if (next_state.xovr[PDL_SEED_LSB +: 4] == 4'h0) begin
      next_state.seed = PDL_SEED_DEFAULT;
    end else begin
      next_state.seed = next_state.xovr[PDL_SEED_LSB +: 4];
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state.neg_fail <= 1'b0;
      state.full_duplex_result <= 1'b0;
      state.speed_100 <= 1'b0;
      state.receive_signal_detected <= 1'b0;
      state.rx_lock <= 1'b0;
      state.gain <= PDL_RST_GAIN;
      state.ind <= PDL_RST_IND[7:0];
      state.xovr <= PDL_RST_XOVR;
      state.rsp <= '0;
      state.amp <= PDL_RST_GAIN[PDL_AMP_LSB +: 2];
      state.seed <= PDL_SEED_DEFAULT;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // indicators
  // ----------------------------------------
  pdl_indicator u_ind_a (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .source_in(state.ind[PDL_IND_A_LSB +: 4]),
    .status_in(phy_status_in),
    .led_out(led_a)
  );

  pdl_indicator u_ind_b (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .source_in(state.ind[PDL_IND_B_LSB +: 4]),
    .status_in(phy_status_in),
    .led_out(led_b)
  );

  assign mgmt_rsp_out = state.rsp;
  assign ctrl_out = '{transmit_amplitude_code: state.amp, indicator_a: led_a,
    indicator_b: led_b, crossover_seed: state.seed};

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_fail_sticky;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (state.neg_fail && !rd_diag) |=> state.neg_fail;
  endproperty
  a_fail_sticky: assert property (p_fail_sticky) else $error("failure flag dropped unread");

  property p_fail_set;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (phy_status_in.neg_done && phy_status_in.neg_fail) |=> state.neg_fail;
  endproperty
  a_fail_set: assert property (p_fail_set) else $error("failure flag not set");

  property p_fail_read;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (rd_diag && state.neg_fail) |=> mgmt_rsp_out.rdata[PDL_BIT_FAIL];
  endproperty
  a_fail_read: assert property (p_fail_read) else $error("read missed failure flag");

  property p_full_duplex_result;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      1'b1 |=> (state.full_duplex_result == $past(phy_status_in.full_duplex_result));
  endproperty
  a_full_duplex_result: assert property (p_full_duplex_result) else $error("duplex result wrong");

  property p_speed;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      rd_diag ##1 1'b1 |-> (mgmt_rsp_out.rdata[PDL_BIT_SPEED] == $past(state.speed_100));
  endproperty
  a_speed: assert property (p_speed) else $error("speed bit wrong");

  property p_sigdet;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      1'b1 |=> (state.receive_signal_detected == $past(phy_status_in.receive_signal_detected));
  endproperty
  a_sigdet: assert property (p_sigdet) else $error("signal detect wrong");

  property p_lock;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      1'b1 |=> (state.rx_lock == $past(phy_status_in.rx_lock));
  endproperty
  a_lock: assert property (p_lock) else $error("lock bit wrong");

  property p_diag_reserved;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      rd_diag |=> (mgmt_rsp_out.rdata[15:13] == 3'h0 && mgmt_rsp_out.rdata[7:0] == 8'h00);
  endproperty
  a_diag_reserved: assert property (p_diag_reserved) else $error("diag reserved set");

  property p_amp;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (wr_hit && mgmt_req_in.addr == PDL_ADDR_GAIN)
        |=> (ctrl_out.transmit_amplitude_code == $past(mgmt_req_in.wdata[15:14]));
  endproperty
  a_amp: assert property (p_amp) else $error("amplitude not taken");

  property p_gain_reserved;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      1'b1 |-> (state.gain[13:0] == 14'h0000);
  endproperty
  a_gain_reserved: assert property (p_gain_reserved) else $error("gain reserved set");

  property p_ind_upper;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (mgmt_req_in.req && !mgmt_req_in.wr && mgmt_req_in.addr == PDL_ADDR_IND)
        |=> (mgmt_rsp_out.rdata[15:8] == 8'h00);
  endproperty
  a_ind_upper: assert property (p_ind_upper) else $error("led upper byte set");

  property p_seed;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (state.xovr[3:0] == 4'h0) |-> (ctrl_out.crossover_seed == 4'h5);
  endproperty
  a_seed: assert property (p_seed) else $error("zero seed not replaced");

  property p_ack;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      mgmt_req_in.req |=> mgmt_rsp_out.ack;
  endproperty
  a_ack: assert property (p_ack) else $error("no answer");

  property p_fail_clear;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (rd_diag && !(phy_status_in.neg_done && phy_status_in.neg_fail)) |=> !state.neg_fail;
  endproperty
  a_fail_clear: assert property (p_fail_clear) else $error("read did not clear flag");

  property p_diag_ro;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (wr_hit && mgmt_req_in.addr == PDL_ADDR_DIAG && !state.neg_fail
        && !(phy_status_in.neg_done && phy_status_in.neg_fail)) |=> !state.neg_fail;
  endproperty
  a_diag_ro: assert property (p_diag_ro) else $error("write reached failure flag");

  property p_gain_keep;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (wr_hit && mgmt_req_in.addr != PDL_ADDR_GAIN) |=> (state.gain == $past(state.gain));
  endproperty
  a_gain_keep: assert property (p_gain_keep) else $error("gain changed by other write");

  property p_ind_keep;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (wr_hit && mgmt_req_in.addr != PDL_ADDR_IND) |=> (state.ind == $past(state.ind));
  endproperty
  a_ind_keep: assert property (p_ind_keep) else $error("led config changed by other write");

  property p_xovr_keep;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (wr_hit && mgmt_req_in.addr != PDL_ADDR_XOVR) |=> (state.xovr == $past(state.xovr));
  endproperty
  a_xovr_keep: assert property (p_xovr_keep) else $error("crossover changed by other write");

  property p_wr_rdata;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (mgmt_req_in.req && mgmt_req_in.wr) |=> (mgmt_rsp_out.rdata == 16'h0000);
  endproperty
  a_wr_rdata: assert property (p_wr_rdata) else $error("write returned data");

  logic addr_mapped;
  assign addr_mapped = mgmt_req_in.addr inside {PDL_ADDR_DIAG, PDL_ADDR_GAIN, PDL_ADDR_IND,
    PDL_ADDR_XOVR};

  property p_hit;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (mgmt_req_in.req && addr_mapped) |=> mgmt_rsp_out.hit;
  endproperty
  a_hit: assert property (p_hit) else $error("mapped address missed");

  property p_miss;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (mgmt_req_in.req && !addr_mapped)
        |=> (!mgmt_rsp_out.hit && mgmt_rsp_out.rdata == 16'h0000);
  endproperty
  a_miss: assert property (p_miss) else $error("unmapped address answered");

  property p_ack_once;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      !mgmt_req_in.req |=> !mgmt_rsp_out.ack;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("answer without request");

  property p_gain_read;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (mgmt_req_in.req && !mgmt_req_in.wr && mgmt_req_in.addr == PDL_ADDR_GAIN)
        |=> (mgmt_rsp_out.rdata == $past(state.gain));
  endproperty
  a_gain_read: assert property (p_gain_read) else $error("gain read wrong");

  property p_ind_read;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (mgmt_req_in.req && !mgmt_req_in.wr && mgmt_req_in.addr == PDL_ADDR_IND)
        |=> (mgmt_rsp_out.rdata[7:0] == $past(state.ind));
  endproperty
  a_ind_read: assert property (p_ind_read) else $error("led config read wrong");

  property p_xovr_read;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (mgmt_req_in.req && !mgmt_req_in.wr && mgmt_req_in.addr == PDL_ADDR_XOVR)
        |=> (mgmt_rsp_out.rdata == $past(state.xovr));
  endproperty
  a_xovr_read: assert property (p_xovr_read) else $error("crossover read wrong");

  property p_diag_read;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      rd_diag |=> (mgmt_rsp_out.rdata == $past(diag_word));
  endproperty
  a_diag_read: assert property (p_diag_read) else $error("diag read wrong");

  property p_seed_copy;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (state.xovr[3:0] != 4'h0) |-> (ctrl_out.crossover_seed == state.xovr[3:0]);
  endproperty
  a_seed_copy: assert property (p_seed_copy) else $error("seed not taken");

  c_fail_read: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    state.neg_fail ##1 rd_diag ##1 !state.neg_fail);
  c_gain_wr: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    wr_hit && mgmt_req_in.addr == PDL_ADDR_GAIN);
  c_ind_wr: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    wr_hit && mgmt_req_in.addr == PDL_ADDR_IND);
  c_seed_zero: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    state.xovr[3:0] == 4'h0);

endmodule
`default_nettype wire

// ---- verif/pdl_mac_model.sv ----
// partner model: mac-side management master issuing single-word accesses
`timescale 1ns/1ps
`default_nettype none
module pdl_mac_model
  import pdl_pkg::*;
(
  // clock
  input wire logic clk_sys_in,
  // management access
  output var pdl_mgmt_req_t req_out,
  input wire pdl_mgmt_rsp_t rsp_in
);
  initial req_out = '0;

  // ----------------------------------------
  // one access: request pulse, then bounded wait for ack
  // ----------------------------------------
  task automatic xfer(input logic wr, input logic [4:0] addr, input logic [15:0] wdata,
                      output logic [15:0] rdata, output logic hit, output logic ok);
    int n;
    ok = 1'b0;
    hit = 1'b0;
    rdata = 16'h0000;
    @(posedge clk_sys_in);
    req_out <= '{1'b1, wr, addr, wdata};
    @(posedge clk_sys_in);
    req_out <= '0;
    for (n = 0; n < 8 && !ok; n++) begin
      @(posedge clk_sys_in);
      if (rsp_in.ack === 1'b1) begin
        ok = 1'b1;
        hit = rsp_in.hit;
        rdata = rsp_in.rdata;
      end
    end
  endtask
endmodule
`default_nettype wire

// ---- verif/phy_diag_led_config_regs_test.sv ----
// testbench: register bank accessed through the management master model
`timescale 1ns/1ps
`default_nettype none
module phy_diag_led_config_regs_test
  import pdl_pkg::*;
;
  logic clk_sys_in;
  logic rst_n_in;
  pdl_mgmt_req_t req;
  pdl_mgmt_rsp_t rsp;
  pdl_phy_status_t phy;
  pdl_ctrl_t ctrl;
  int err_total;
  int n_tests;
  int i;
  int k;
  int c;
  logic [8:0] em;

  pdl_regs dut (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .mgmt_req_in(req),
    .mgmt_rsp_out(rsp),
    .phy_status_in(phy),
    .ctrl_out(ctrl)
  );

  pdl_mac_model mac (
    .clk_sys_in(clk_sys_in),
    .req_out(req),
    .rsp_in(rsp)
  );

  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    #200000;
    err_total++;
    wrap_up();
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] exp, input logic exp_hit);
    logic [15:0] d;
    logic h;
    logic ok;
    mac.xfer(1'b0, a, 16'h0000, d, h, ok);
    chk("ack", 16'h0001, {15'h0000, ok});
    chk("hit", {15'h0000, exp_hit}, {15'h0000, h});
    chk("rdata", exp, d);
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    logic [15:0] d;
    logic h;
    logic ok;
    mac.xfer(1'b1, a, v, d, h, ok);
    chk("write ack", 16'h0001, {15'h0000, ok});
    chk("write rdata", 16'h0000, d);
  endtask

  // status bits: done fail fdx speed sig lock link act blink
  task automatic set_phy(input logic [8:0] v);
    @(posedge clk_sys_in);
    phy <= v;
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    err_total = 0;
    n_tests = 0;
    rst_n_in = 1'b0;
    phy = '0;
    repeat (4) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    rd(5'h12, 16'h0000, 1'b1);
    rd(5'h13, 16'h4000, 1'b1);
    rd(5'h17, 16'h0010, 1'b1);
    rd(5'h18, 16'h00c0, 1'b1);
    chk("amplitude", 16'h0001, {14'h0000, ctrl.transmit_amplitude_code});
    chk("seed", 16'h0005, {12'h000, ctrl.crossover_seed});
    rd(5'h10, 16'h0000, 1'b0);
    rd(5'h1f, 16'h0000, 1'b0);
    // amplitude codes and unstored low bits
    for (i = 0; i < 4; i++) begin
      wr(5'h13, {i[1:0], 14'h3fff});
      rd(5'h13, {i[1:0], 14'h0000}, 1'b1);
      chk("amplitude", 16'(i), {14'h0000, ctrl.transmit_amplitude_code});
    end
    wr(5'h17, 16'hffff);
    rd(5'h17, 16'h00ff, 1'b1);
    wr(5'h10, 16'hffff);
    rd(5'h17, 16'h00ff, 1'b1);
    rd(5'h13, 16'hc000, 1'b1);
    wr(5'h12, 16'hffff);
    rd(5'h12, 16'h0000, 1'b1);
    // crossover seed substitution
    wr(5'h18, 16'h0000);
    chk("seed", 16'h0005, {12'h000, ctrl.crossover_seed});
    rd(5'h18, 16'h0000, 1'b1);
    wr(5'h18, 16'h1233);
    chk("seed", 16'h0003, {12'h000, ctrl.crossover_seed});
    rd(5'h18, 16'h1233, 1'b1);
    // status reporting
    set_phy(9'h050);
    rd(5'h12, 16'h0a00, 1'b1);
    set_phy(9'h028);
    rd(5'h12, 16'h0500, 1'b1);
    // failure flag: sticky, cleared by read
    set_phy(9'h100);
    set_phy(9'h000);
    rd(5'h12, 16'h0000, 1'b1);
    set_phy(9'h180);
    set_phy(9'h000);
    repeat (3) @(posedge clk_sys_in);
    rd(5'h12, 16'h1000, 1'b1);
    rd(5'h12, 16'h0000, 1'b1);
    // indicator source decode, a gets code c and b gets 8-c
    for (k = 0; k < 2; k++) begin
      set_phy(k != 0 ? 9'h044 : 9'h027);
      em = k != 0 ? 9'h1c1 : 9'h023;
      for (c = 0; c < 9; c++) begin
        wr(5'h17, {8'h00, 4'(8 - c), 4'(c)});
        repeat (3) @(posedge clk_sys_in);
        chk("indicator_a", {15'h0000, em[c]}, {15'h0000, ctrl.indicator_a});
        chk("indicator_b", {15'h0000, em[8-c]}, {15'h0000, ctrl.indicator_b});
      end
    end
    // reset in mid-run restores the reset values and drops a pending failure
    set_phy(9'h180);
    set_phy(9'h000);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    rd(5'h12, 16'h0000, 1'b1);
    rd(5'h13, 16'h4000, 1'b1);
    rd(5'h17, 16'h0010, 1'b1);
    rd(5'h18, 16'h00c0, 1'b1);
    chk("seed", 16'h0005, {12'h000, ctrl.crossover_seed});
    chk("amplitude", 16'h0001, {14'h0000, ctrl.transmit_amplitude_code});
    wrap_up();
  end
endmodule
`default_nettype wire
